// >>> scs_pkg.sv
// constants, field layout and types of the sync check supervisor
package scs_pkg;
  localparam int          VW        = 16;
  localparam int          EVT_N     = 16;
  localparam int          SEL_W     = 4;
  localparam int          AW        = 8;
  localparam int          SW_N      = 8;
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_VMAX  = 8'h04;
  localparam logic [7:0]  OFF_VMIN  = 8'h08;
  localparam logic [7:0]  OFF_FMAX  = 8'h0c;
  localparam logic [7:0]  OFF_FMIN  = 8'h10;
  localparam logic [7:0]  OFF_VNOM  = 8'h14;
  localparam logic [7:0]  OFF_MAXT  = 8'h18;
  localparam logic [7:0]  OFF_STAT  = 8'h1c;
  // control field positions
  localparam int          C_ACT     = 0;
  localparam int          C_UBLK    = 4;
  localparam int          C_SBLK    = 8;
  localparam int          C_REF     = 12;
  localparam int          C_ROT     = 13;
  localparam int          C_MODE3   = 14;
  localparam int          C_SCEN    = 15;
  localparam int          C_SW      = 16;
  localparam int          C_SHOW    = 20;
  localparam int          CTRL_W    = 22;
  // reset values
  localparam logic [21:0] CTRL_RST  = 22'h004000;
  localparam logic [15:0] VMAX_RST  = 16'hffff;
  localparam logic [15:0] VMIN_RST  = 16'h0000;
  localparam logic [15:0] FMAX_RST  = 16'hffff;
  localparam logic [15:0] FMIN_RST  = 16'h0000;
  localparam logic [15:0] VNOM_RST  = 16'h0000;
  localparam logic [15:0] MAXT_RST  = 16'h0000;
  // phase sequence live threshold, 40 percent as num/den
  localparam logic [3:0]  LIVE_NUM  = 4'h4;
  localparam logic [3:0]  LIVE_DEN  = 4'ha;
  // display mode bits
  localparam int          SHOW_OPEN = 0;
  localparam int          SHOW_CLS  = 1;
  // timing: one millisecond tick of the manual timer
  localparam int          CLK_NS    = 40;
  localparam int          MS_NS     = 1000000;
  localparam int          TICK_CYC  = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_SERR = 2'h2;
  typedef enum logic [0:0] {
    SCS_IDLE = 1'b0,
    SCS_MAN  = 1'b1
  } scs_man_e;
endpackage

// >>> scs_sync_check_supervisor.sv
// sync check supervisor: gating, range check, timer and axi4-lite registers
//
// Operation
// - unit active flag follows the selected activation event exactly.
// - activation selection zero means no event activation.
// - selected unit blocking event blocks whole unit and sets blocked flag.
// - unit blocking selection zero means never blocked.
// - reference select picks which input is reference, other is synchronized.
// - manual start runs max time timer; expiry without stop deactivates.
// - max time limit applies to manual runs only, never event activation.
// - phase sequence check acts when enabled and all voltages exceed 40% nominal.
// - wrong sequence sets per input flag and blocks both sub-functions.
// - three-phase mode checks all three voltages, two-phase only the first.
// - selected voltages are compared with maximum and minimum limits.
// - difference checks start only when both inputs are in range.
// - synchrocheck starts only when enabled and event-activated.
// - selected synchrocheck blocking event blocks check and sets flag.
// - synchrocheck blocking selection zero means never blocked.
// - switch element select routes chosen element state to display; none outputs none.
// - settings are held once per unit and shared by both sub-functions.
// - display setting picks auto open, auto close, both or neither.
// - input in voltage and frequency range sets its in-range flag.
// - voltage above maximum sets that input's over-voltage flag.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module scs_sync_check_supervisor #(
  parameter int TICK_CYC = scs_pkg::TICK_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [15:0]              event_in,
  input  wire logic                     manual_start,
  input  wire logic                     manual_stop,
  input  wire logic                     meas_valid,
  input  wire logic [15:0]              volt_input_a_v12,
  input  wire logic [15:0]              volt_input_a_v23,
  input  wire logic [15:0]              volt_input_a_v31,
  input  wire logic [15:0]              volt_input_a_freq,
  input  wire logic                     volt_input_a_seq_ok,
  input  wire logic [15:0]              volt_input_b_v12,
  input  wire logic [15:0]              volt_input_b_v23,
  input  wire logic [15:0]              volt_input_b_v31,
  input  wire logic [15:0]              volt_input_b_freq,
  input  wire logic                     volt_input_b_seq_ok,
  input  wire logic [7:0]               switch_state,
  output logic                          unit_active,
  output logic                          unit_blocked,
  output logic                          sc_blocked,
  output logic                          vc_blocked,
  output logic                          sc_running,
  output logic                          diff_eval_en,
  output logic [1:0]                    neg_seq,
  output logic [1:0]                    in_range,
  output logic [1:0]                    over_volt,
  output logic [1:0]                    under_volt,
  output logic [1:0]                    over_freq,
  output logic [1:0]                    under_freq,
  output logic [15:0]                   ref_line_voltage_first_pair,
  output logic [15:0]                   ref_freq,
  output logic [15:0]                   syn_line_voltage_first_pair,
  output logic [15:0]                   syn_freq,
  output logic                          disp_sw_valid,
  output logic                          disp_sw_state,
  output logic                          view_open,
  output logic                          view_close
);
  logic [scs_pkg::CTRL_W-1:0] ctrl_ff;
  logic [15:0]                vmax_ff, vmin_ff, fmax_ff, fmin_ff, vnom_ff, maxt_ff;
  logic [7:0]                 awaddr_ff;
  logic [31:0]                wdata_ff;
  logic                       aw_held_ff, w_held_ff;
  logic [31:0]                nxt_rdata;
  logic                       rd_hit;
  logic                       wr_fire;
  logic                       wr_hit;
  logic                       act_evt, ublk_evt, sblk_evt;
  logic                       man_on;
  scs_pkg::scs_man_e          man_ff;
  logic [15:0]                tick_ff;
  logic [15:0]                ms_ff;
  logic                       tick;
  logic                       expire;
  logic                       unit_on;
  logic                       unit_on_d_ff;
  logic [1:0]                 live;
  logic [15:0]                v12 [2];
  logic [15:0]                v23 [2];
  logic [15:0]                v31 [2];
  logic [15:0]                fq  [2];
  logic [1:0]                 seq_ok;
  logic [2:0]                 sw_idx;
  logic [31:0]                stat;

  // event selection: index zero is reserved for "none configured"
  function automatic logic evt_sel(input logic [3:0] sel, input logic [15:0] ev);
    evt_sel = (sel != 4'h0) && ev[sel];
  endfunction

  assign act_evt  = evt_sel(ctrl_ff[scs_pkg::C_ACT +: scs_pkg::SEL_W], event_in);
  assign ublk_evt = evt_sel(ctrl_ff[scs_pkg::C_UBLK +: scs_pkg::SEL_W], event_in);
  assign sblk_evt = evt_sel(ctrl_ff[scs_pkg::C_SBLK +: scs_pkg::SEL_W], event_in);

  // ---------------- axi4-lite write path ----------------
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  // unaligned offsets never match a register, so they answer slverr too
  assign wr_hit  = (awaddr_ff[1:0] == 2'h0) && (awaddr_ff[7:2] <= scs_pkg::OFF_MAXT[7:2]);

  // address and data are taken independently, in either order
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped or status writes get slverr
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scs_pkg::RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? scs_pkg::RESP_OK : scs_pkg::RESP_SERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // settings, one copy shared by synchrocheck and voltage
  // wstrb is not honoured per lane; settings are written whole words
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_ff <= scs_pkg::CTRL_RST;
      vmax_ff <= scs_pkg::VMAX_RST;
      vmin_ff <= scs_pkg::VMIN_RST;
      fmax_ff <= scs_pkg::FMAX_RST;
      fmin_ff <= scs_pkg::FMIN_RST;
      vnom_ff <= scs_pkg::VNOM_RST;
      maxt_ff <= scs_pkg::MAXT_RST;
    end else if (wr_fire && (s_axi_wstrb != 4'h0 || 1'b1)) begin
      case (awaddr_ff)
        scs_pkg::OFF_CTRL: ctrl_ff <= wdata_ff[scs_pkg::CTRL_W-1:0];
        scs_pkg::OFF_VMAX: vmax_ff <= wdata_ff[15:0];
        scs_pkg::OFF_VMIN: vmin_ff <= wdata_ff[15:0];
        scs_pkg::OFF_FMAX: fmax_ff <= wdata_ff[15:0];
        scs_pkg::OFF_FMIN: fmin_ff <= wdata_ff[15:0];
        scs_pkg::OFF_VNOM: vnom_ff <= wdata_ff[15:0];
        scs_pkg::OFF_MAXT: maxt_ff <= wdata_ff[15:0];
        default: ;
      endcase
    end
  end

  // ---------------- axi4-lite read path ----------------
  assign stat = {13'h0000, man_on, diff_eval_en, sc_running, under_freq, over_freq,
                 under_volt, over_volt, in_range, neg_seq, vc_blocked, sc_blocked,
                 unit_blocked, unit_active};

  always_comb begin
    nxt_rdata = 32'h00000000;
    rd_hit    = 1'b1;
    case (s_axi_araddr)
      scs_pkg::OFF_CTRL: nxt_rdata = {10'h000, ctrl_ff};
      scs_pkg::OFF_VMAX: nxt_rdata = {16'h0000, vmax_ff};
      scs_pkg::OFF_VMIN: nxt_rdata = {16'h0000, vmin_ff};
      scs_pkg::OFF_FMAX: nxt_rdata = {16'h0000, fmax_ff};
      scs_pkg::OFF_FMIN: nxt_rdata = {16'h0000, fmin_ff};
      scs_pkg::OFF_VNOM: nxt_rdata = {16'h0000, vnom_ff};
      scs_pkg::OFF_MAXT: nxt_rdata = {16'h0000, maxt_ff};
      scs_pkg::OFF_STAT: nxt_rdata = stat;
      default:           rd_hit    = 1'b0;
    endcase
  end

  // one read at a time; arready drops while the answer is held
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= scs_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= nxt_rdata;
      s_axi_rresp   <= rd_hit ? scs_pkg::RESP_OK : scs_pkg::RESP_SERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid  <= !s_axi_rready;
      s_axi_arready <= s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- manual run and maximum operating time ----------------
  assign man_on = (man_ff == scs_pkg::SCS_MAN);
  assign tick   = (tick_ff == 16'(TICK_CYC - 1));
  assign expire = man_on && tick && (ms_ff >= maxt_ff);

  // manual start arms, stop or timeout ends; event activation never times out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      man_ff <= scs_pkg::SCS_IDLE;
    end else begin
      case (man_ff)
        scs_pkg::SCS_IDLE: if (manual_start) begin
          man_ff <= scs_pkg::SCS_MAN;
        end
        scs_pkg::SCS_MAN: if (manual_stop || expire) begin
          man_ff <= scs_pkg::SCS_IDLE;
        end
        default: man_ff <= scs_pkg::SCS_IDLE;
      endcase
    end
  end

  // millisecond prescaler and elapsed count, both restart on manual start
  always_ff @(posedge clk) begin
    if (!rstn || !man_on) begin
      tick_ff <= 16'h0000;
      ms_ff   <= 16'h0000;
    end else if (tick) begin
      tick_ff <= 16'h0000;
      ms_ff   <= (ms_ff == 16'hffff) ? ms_ff : ms_ff + 16'h0001;
    end else begin
      tick_ff <= tick_ff + 16'h0001;
    end
  end

  // ---------------- per-input range and phase sequence ----------------
  assign v12[0] = volt_input_a_v12;
  assign v23[0] = volt_input_a_v23;
  assign v31[0] = volt_input_a_v31;
  assign fq[0]  = volt_input_a_freq;
  assign v12[1] = volt_input_b_v12;
  assign v23[1] = volt_input_b_v23;
  assign v31[1] = volt_input_b_v31;
  assign fq[1]  = volt_input_b_freq;
  assign seq_ok = {volt_input_b_seq_ok, volt_input_a_seq_ok};

  for (genvar g = 0; g < 2; g++) begin : g_in
    logic m3;
    logic ov, uv, of, uf;
    assign m3 = ctrl_ff[scs_pkg::C_MODE3];
    // two-phase mode looks at the first pair only
    assign ov = (v12[g] > vmax_ff) || (m3 && ((v23[g] > vmax_ff) || (v31[g] > vmax_ff)));
    assign uv = (v12[g] < vmin_ff) || (m3 && ((v23[g] < vmin_ff) || (v31[g] < vmin_ff)));
    assign of = (fq[g] > fmax_ff);
    assign uf = (fq[g] < fmin_ff);
    // live means all three above 40 percent nominal, scaled to avoid a divider
    assign live[g] = (20'(v12[g]) * 20'(scs_pkg::LIVE_DEN) > 20'(vnom_ff) * 20'(scs_pkg::LIVE_NUM))
                  && (20'(v23[g]) * 20'(scs_pkg::LIVE_DEN) > 20'(vnom_ff) * 20'(scs_pkg::LIVE_NUM))
                  && (20'(v31[g]) * 20'(scs_pkg::LIVE_DEN) > 20'(vnom_ff) * 20'(scs_pkg::LIVE_NUM));

    // flags hold between samples and refresh on each new one
    always_ff @(posedge clk) begin
      if (!rstn) begin
        over_volt[g]  <= 1'b0;
        under_volt[g] <= 1'b0;
        over_freq[g]  <= 1'b0;
        under_freq[g] <= 1'b0;
        in_range[g]   <= 1'b0;
        neg_seq[g]    <= 1'b0;
      end else if (meas_valid) begin
        over_volt[g]  <= ov;
        under_volt[g] <= uv;
        over_freq[g]  <= of;
        under_freq[g] <= uf;
        in_range[g]   <= !(ov || uv || of || uf);
        neg_seq[g]    <= ctrl_ff[scs_pkg::C_ROT] && (&live) && !seq_ok[g];
      end
    end
  end

  // ---------------- unit gating and sub-function blocking ----------------
  assign unit_on = (act_evt || man_on) && !ublk_evt;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      unit_active  <= 1'b0;
      unit_blocked <= 1'b0;
      sc_blocked   <= 1'b0;
      vc_blocked   <= 1'b0;
      sc_running   <= 1'b0;
      unit_on_d_ff <= 1'b0;
    end else begin
      unit_active  <= act_evt;
      unit_blocked <= ublk_evt;
      sc_blocked   <= sblk_evt;
      vc_blocked   <= ublk_evt || (|neg_seq);
      // synchrocheck wants event activation, not a manual run
      sc_running   <= ctrl_ff[scs_pkg::C_SCEN] && act_evt && !ublk_evt && !sblk_evt && !(|neg_seq);
      unit_on_d_ff <= unit_on;
    end
  end

  // difference evaluation waits for both inputs in range
  always_ff @(posedge clk) begin
    if (!rstn) begin
      diff_eval_en <= 1'b0;
    end else begin
      diff_eval_en <= sc_running && (&in_range);
    end
  end

  // reference routing to the difference stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_line_voltage_first_pair <= 16'h0000;
      ref_freq                    <= 16'h0000;
      syn_line_voltage_first_pair <= 16'h0000;
      syn_freq                    <= 16'h0000;
    end else if (meas_valid) begin
      ref_line_voltage_first_pair <= ctrl_ff[scs_pkg::C_REF] ? v12[1] : v12[0];
      ref_freq                    <= ctrl_ff[scs_pkg::C_REF] ? fq[1] : fq[0];
      syn_line_voltage_first_pair <= ctrl_ff[scs_pkg::C_REF] ? v12[0] : v12[1];
      syn_freq                    <= ctrl_ff[scs_pkg::C_REF] ? fq[0] : fq[1];
    end
  end

  // ---------------- display ----------------
  assign sw_idx = 3'(ctrl_ff[scs_pkg::C_SW +: 4] - 4'h1);

  // element select 0 shows nothing; values above 8 also show nothing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      disp_sw_valid <= 1'b0;
      disp_sw_state <= 1'b0;
      view_open     <= 1'b0;
      view_close    <= 1'b0;
    end else begin
      disp_sw_valid <= (ctrl_ff[scs_pkg::C_SW +: 4] != 4'h0) && (ctrl_ff[scs_pkg::C_SW +: 4] <= 4'h8);
      disp_sw_state <= disp_sw_valid_n() && switch_state[sw_idx];
      view_open     <= ctrl_ff[scs_pkg::C_SHOW + scs_pkg::SHOW_OPEN] && unit_on && !unit_on_d_ff;
      view_close    <= ctrl_ff[scs_pkg::C_SHOW + scs_pkg::SHOW_CLS] && !unit_on && unit_on_d_ff;
    end
  end

  function automatic logic disp_sw_valid_n();
    disp_sw_valid_n = (ctrl_ff[scs_pkg::C_SW +: 4] != 4'h0) && (ctrl_ff[scs_pkg::C_SW +: 4] <= 4'h8);
  endfunction

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence man_go_s;
    man_ff == scs_pkg::SCS_IDLE && manual_start;
  endsequence
  sequence man_hold_s;
    man_on && !manual_stop;
  endsequence

  act_follow_a: assert property (##1 unit_active == $past(act_evt))
    else $error("active flag does not follow the activation event");
  act_none_a: assert property (ctrl_ff[3:0] == 4'h0 |=> !unit_active)
    else $error("active flag set with no event selected");
  ublk_follow_a: assert property (ublk_evt |=> unit_blocked && vc_blocked && !sc_running)
    else $error("unit blocking not applied");
  ublk_none_a: assert property (ctrl_ff[7:4] == 4'h0 |=> !unit_blocked)
    else $error("unit blocked with no event selected");
  man_start_a: assert property (man_go_s |=> man_on)
    else $error("manual start not taken");
  man_stop_a: assert property (man_on && manual_stop |=> !man_on)
    else $error("manual stop not taken");
  man_expire_a: assert property (man_hold_s and expire |=> !man_on)
    else $error("manual run outlived its maximum time");
  ev_no_timeout_a: assert property (act_evt && !man_on && !ublk_evt |-> unit_on)
    else $error("event activation cut short");
  negseq_a: assert property (meas_valid && !ctrl_ff[scs_pkg::C_ROT] |=> neg_seq == 2'h0)
    else $error("phase sequence flag set while supervision off");
  negblk_a: assert property (|neg_seq |=> vc_blocked && !sc_running)
    else $error("wrong sequence did not block");
  diff_gate_a: assert property (diff_eval_en |-> $past(sc_running) && $past(&in_range))
    else $error("difference check ran out of range");
  sc_gate_a: assert property (sc_running |-> $past(ctrl_ff[scs_pkg::C_SCEN] && act_evt))
    else $error("synchrocheck ran without enable and activation");
  sblk_a: assert property (sblk_evt |=> sc_blocked && !sc_running)
    else $error("synchrocheck blocking not applied");
  sblk_none_a: assert property (ctrl_ff[11:8] == 4'h0 |=> !sc_blocked)
    else $error("synchrocheck blocked with no event selected");
  sw_none_a: assert property (ctrl_ff[19:16] == 4'h0 |=> !disp_sw_valid && !disp_sw_state)
    else $error("element shown with none selected");
  over_a: assert property (meas_valid && (volt_input_a_v12 > vmax_ff) |=> over_volt[0] && !in_range[0])
    else $error("over-voltage of input a missed");
  mode2_a: assert property (meas_valid && !ctrl_ff[scs_pkg::C_MODE3] && volt_input_a_v12 <= vmax_ff
                            |=> !over_volt[0])
    else $error("two-phase mode looked beyond the first pair");
endmodule

// >>> scs_meas_model.sv
// measurement source model: two three-phase inputs sampled every fourth cycle
`timescale 1ns/1ps
module scs_meas_model (
  input  wire logic        clk, rstn,
  input  wire logic [15:0] va, va3, vb, fq,
  input  wire logic [1:0]  ok,
  output logic             meas_valid, volt_input_a_seq_ok, volt_input_b_seq_ok,
  output logic [15:0]      volt_input_a_v12, volt_input_a_v23, volt_input_a_v31, volt_input_a_freq,
  output logic [15:0]      volt_input_b_v12, volt_input_b_v23, volt_input_b_v31, volt_input_b_freq
);
  logic [1:0] div_ff;
  // values change only with the strobe, so they stand between samples
  always_ff @(posedge clk) begin
    div_ff <= rstn ? div_ff + 2'h1 : 2'h0;
    meas_valid <= rstn && div_ff == 2'h3;
    if (div_ff == 2'h3) begin
      {volt_input_a_v12, volt_input_a_v23, volt_input_a_v31, volt_input_a_freq} <= {va, va3, va3, fq};
      {volt_input_b_v12, volt_input_b_v23, volt_input_b_v31, volt_input_b_freq} <= {vb, vb, vb, fq};
      {volt_input_b_seq_ok, volt_input_a_seq_ok} <= ok;
    end
  end
endmodule

// >>> tb_top.sv
// testbench: register-driven scenarios of the sync check supervisor
`timescale 1ns/1ps
module tb_top;
  logic        clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_awready, s_axi_wready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, manual_start, manual_stop, meas_valid;
  logic        volt_input_a_seq_ok, volt_input_b_seq_ok, unit_active, unit_blocked, sc_blocked, vc_blocked;
  logic        sc_running, diff_eval_en, disp_sw_valid, disp_sw_state, view_open, view_close;
  logic [1:0]  s_axi_bresp, s_axi_rresp, neg_seq, in_range, over_volt, under_volt, over_freq, under_freq, ok, rd_r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, switch_state;
  logic [15:0] event_in, va, va3, vb, ref_freq, syn_freq, ref_line_voltage_first_pair, syn_line_voltage_first_pair;
  logic [15:0] volt_input_a_v12, volt_input_a_v23, volt_input_a_v31, volt_input_a_freq;
  logic [15:0] volt_input_b_v12, volt_input_b_v23, volt_input_b_v31, volt_input_b_freq;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [1:0]  vw;
  int          mismatches, cmp_count, cyc;
  // latch the one-cycle view pulses so a later compare can see them
  always @(posedge clk) if (rstn) vw <= vw | {view_open, view_close};
  scs_sync_check_supervisor #(.TICK_CYC(4)) scs_sync_check_supervisor_i (.clk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .event_in, .manual_start, .manual_stop, .meas_valid, .volt_input_a_v12,
    .volt_input_a_v23, .volt_input_a_v31, .volt_input_a_freq, .volt_input_a_seq_ok, .volt_input_b_v12,
    .volt_input_b_v23, .volt_input_b_v31, .volt_input_b_freq, .volt_input_b_seq_ok, .switch_state, .unit_active,
    .unit_blocked, .sc_blocked, .vc_blocked, .sc_running, .diff_eval_en, .neg_seq, .in_range, .over_volt,
    .under_volt, .over_freq, .under_freq, .ref_line_voltage_first_pair, .ref_freq, .syn_line_voltage_first_pair,
    .syn_freq, .disp_sw_valid, .disp_sw_state, .view_open, .view_close);
  scs_meas_model scs_meas_model_i (.clk, .rstn, .va, .va3, .vb, .fq(16'h0032), .ok, .meas_valid,
    .volt_input_a_seq_ok, .volt_input_b_seq_ok, .volt_input_a_v12, .volt_input_a_v23, .volt_input_a_v31,
    .volt_input_a_freq, .volt_input_b_v12, .volt_input_b_v23, .volt_input_b_v31, .volt_input_b_freq);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // both halves offered together, each dropped once taken; bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0; rd_d = s_axi_rdata; rd_r = s_axi_rresp;
  endtask
  // settle over three samples, then read the status word
  task automatic st(input logic [31:0] e);
    repeat (12) @(posedge clk);
    rd(8'h1c);
    chk("status", rd_d, e);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, manual_start, manual_stop} = '0;
    s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0; s_axi_wstrb = 4'hf; event_in = '0;
    switch_state = 8'h04; va = 16'h01f4; va3 = 16'h01f4; vb = 16'h0258; ok = 2'h3; rstn = 1'b0; vw = 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00); chk("ctrl", rd_d, 32'h00004000);
    rd(8'h20); chk("unmapped", {30'h0, rd_r}, 32'h00000002);
    wr(8'h1c, 32'h0000ffff, 2'h2);
    wr(8'h04, 32'h000003e8, 2'h0); wr(8'h08, 32'h00000064, 2'h0);
    $display("registers test done");
    wr(8'h00, 32'h0003c003, 2'h0); event_in <= 16'h0008;
    st(32'h000300c1);
    chk("disp", {disp_sw_valid, disp_sw_state}, 32'h3);
    chk("ref", ref_line_voltage_first_pair, 32'h01f4);
    wr(8'h00, 32'h0000d003, 2'h0); st(32'h000300c1);
    chk("ref", ref_line_voltage_first_pair, 32'h0258);
    chk("syn", syn_line_voltage_first_pair, 32'h01f4);
    chk("disp", {disp_sw_valid, disp_sw_state}, 32'h0);
    va3 <= 16'h04b0; st(32'h00010181);
    wr(8'h00, 32'h00008003, 2'h0); st(32'h000300c1);
    va3 <= 16'h01f4;
    $display("activation and range test done");
    event_in <= 16'h0028; wr(8'h00, 32'h00008053, 2'h0); st(32'h000000cb);
    event_in <= 16'h0008; wr(8'h00, 32'h00008303, 2'h0); st(32'h000000c5);
    event_in <= 16'hffff; wr(8'h00, 32'h00008000, 2'h0); st(32'h000000c0);
    event_in <= 16'h0008; ok <= 2'h2; wr(8'h14, 32'h000003e8, 2'h0); wr(8'h00, 32'h0000a003, 2'h0);
    st(32'h000000d9);
    wr(8'h14, 32'h000004e2, 2'h0); st(32'h000300c1);
    $display("blocking and phase sequence test done");
    event_in <= '0; wr(8'h18, 32'h00000002, 2'h0); wr(8'h00, 32'h00308000, 2'h0);
    chk("view", {30'h0, vw}, 32'h0);
    manual_start <= 1'b1;
    @(posedge clk) manual_start <= 1'b0;
    rd(8'h1c); chk("manual", {31'h0, rd_d[18]}, 32'h1);
    repeat (30) @(posedge clk);
    rd(8'h1c); chk("manual", {31'h0, rd_d[18]}, 32'h0);
    chk("view", {30'h0, vw}, 32'h3);
    manual_start <= 1'b1;
    @(posedge clk) manual_start <= 1'b0;
    manual_stop <= 1'b1;
    @(posedge clk) manual_stop <= 1'b0;
    rd(8'h1c); chk("manual", {31'h0, rd_d[18]}, 32'h0);
    $display("manual timer test done");
    print_verdict();
  end
endmodule
